// ### include/fpx_defines.svh
// register map, field positions, reset values and constants of the fp trap unit
`ifndef FPX_DEFINES_SVH
`define FPX_DEFINES_SVH
`define FPX_OFF_CTRL 8'h00
`define FPX_OFF_STATUS 8'h04
`define FPX_OFF_MASK 8'h08
`define FPX_OFF_COUNT 8'h0C
`define FPX_INVALID_TRAP_DISABLE 0
`define FPX_DIVZERO_TRAP_DISABLE 1
`define FPX_OVERFLOW_TRAP_DISABLE 2
`define FPX_UNDERFLOW_TRAP_DISABLE 3
`define FPX_INEXACT_TRAP_DISABLE 4
`define FPX_DIS_W 5
`define FPX_RND_LO 8
`define FPX_RND_HI 9
`define FPX_CAUSE_W 7
`define FPX_DIS_RST 5'h00
`define FPX_RND_RST 2'h2
`define FPX_MASK_RST 7'h00
`define FPX_TRUE_VAL 64'h4000000000000000
`endif

// ### include/fpx_pkg.sv
// types of the fp trap unit
package fpx_pkg;
   typedef enum logic [3:0] {
      op_add, op_sub, op_mul, op_div, op_cvt_ff, op_cvt_fi, op_cvt_if, op_cmp,
      op_load, op_store, op_cpys, op_other
   } fpx_op_t;
   typedef enum logic [1:0] {rnd_chop, rnd_minus, rnd_normal, rnd_plus} fpx_rnd_t;
   typedef enum logic [2:0] {cls_finite, cls_zero, cls_denorm, cls_inf, cls_qnan, cls_snan} fpx_cls_t;
   typedef enum logic [2:0] {pr_eq, pr_ne, pr_lt, pr_le, pr_gt, pr_ge, pr_un} fpx_pred_t;
   typedef struct packed {
      logic sw;
      logic unf;
      logic ine;
      logic dyn_rnd;
      fpx_rnd_t rnd;
   } fpx_qual_t;
   typedef struct packed {
      logic integer_overflow_exception;
      logic unimpl;
      logic ine;
      logic unf;
      logic ovf;
      logic dze;
      logic inv;
   } fpx_cause_t;
   typedef struct packed {
      logic valid;
      fpx_op_t op;
      fpx_qual_t qual;
      fpx_pred_t pred;
      logic fmt_a;
      logic fmt_b;
      fpx_cls_t cls_a;
      fpx_cls_t cls_b;
      logic ovf;
      logic dze;
      logic inv_new;
      logic tiny;
      logic inexact;
      logic integer_overflow_exception;
      logic lt;
      logic eq;
      logic unord;
      logic [63:0] result;
   } fpx_req_t;
   typedef struct packed {
      logic valid;
      logic trap;
      logic unpredictable;
      fpx_rnd_t rnd;
      fpx_cause_t cause;
      logic [63:0] result;
   } fpx_resp_t;
endpackage

// ### rtl/fpx_trap_unit.sv
// fp exception and trap decision unit with ahb-lite register slave
// Operation
// - round to nearest and chopped always in hardware; directed modes optional
// - add, sub, mul, div, conversions and compare in hardware; rest to software
// - loads, stores, copy-sign never check operands nor raise invalid
// - compares need equal formats; seven predicates answer true or false
// - infinity operand or created infinity traps unless overflow disabled; not compares
// - nan operand or created nan traps unless invalid disabled
// - negative zero operands accepted; signed zero results follow ieee rules
// - tininess judged after rounding
// - traps set by instruction qualifiers plus control disable bits only
// - without underflow qualifier an underflow writes plus zero, no trap
// - software qualifier: overflow, divzero, invalid trap, destination unpredictable
// - software plus underflow qualifier: underflow traps and writes true zero
// - such instructions give correctly signed zero when no underflow
// - inexact qualifier traps on inexact results
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fpx_defines.svh"
module fpx_trap_unit import fpx_pkg::*; #(
   parameter bit HW_DIRECTED = 1'b1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire fpx_req_t req,
   output fpx_resp_t resp,
   output fpx_rnd_t round_mode,
   output logic irq
);
   logic [`FPX_DIS_W-1:0] dis;
   logic [`FPX_CAUSE_W-1:0] status;
   logic [`FPX_CAUSE_W-1:0] mask;
   logic [15:0] trap_cnt;
   logic wr_pend;
   logic rd_pend;
   logic [7:0] wr_addr;
   logic [7:0] rd_addr;
   logic ap_ok;
   logic is_mv;
   logic is_cmp;
   logic nan_in;
   logic inf_in;
   fpx_rnd_t rnd_use;
   fpx_cause_t next_cause;
   logic [63:0] next_result;
   logic next_trap;
   logic next_unpred;
   logic [`FPX_CAUSE_W-1:0] w1c;

   function automatic logic is_move(input fpx_op_t o);
      return o == op_load || o == op_store || o == op_cpys;
   endfunction

   function automatic logic is_nan(input fpx_cls_t c);
      return c == cls_qnan || c == cls_snan;
   endfunction

   function automatic logic pred_true(input fpx_req_t r);
      case (r.pred)
         pr_eq: return !r.unord && r.eq;
         pr_ne: return r.unord || !r.eq;
         pr_lt: return !r.unord && r.lt;
         pr_le: return !r.unord && (r.lt || r.eq);
         pr_gt: return !r.unord && !r.lt && !r.eq;
         pr_ge: return !r.unord && !r.lt;
         pr_un: return r.unord;
         default: return 1'b0;
      endcase
   endfunction

   // trap decision
   always_comb begin
      is_mv = is_move(req.op);
      is_cmp = req.op == op_cmp;
      nan_in = is_nan(req.cls_a) || is_nan(req.cls_b);
      inf_in = req.cls_a == cls_inf || req.cls_b == cls_inf;
      rnd_use = req.qual.dyn_rnd ? round_mode : req.qual.rnd;
      next_cause = '0;
      next_result = req.result;
      if (!is_mv) begin
         next_cause.unimpl = req.op == op_other || (is_cmp && req.fmt_a != req.fmt_b)
            || (!HW_DIRECTED && (rnd_use == rnd_plus || rnd_use == rnd_minus))
            || req.cls_a == cls_denorm || req.cls_b == cls_denorm;
         next_cause.ovf = ((inf_in && !is_cmp) || req.ovf) && !dis[`FPX_OVERFLOW_TRAP_DISABLE];
         next_cause.dze = req.dze && !dis[`FPX_DIVZERO_TRAP_DISABLE];
         next_cause.inv = (nan_in || req.inv_new) && !dis[`FPX_INVALID_TRAP_DISABLE];
         next_cause.integer_overflow_exception = req.integer_overflow_exception && req.op == op_cvt_fi && !dis[`FPX_INVALID_TRAP_DISABLE];
         next_cause.unf = req.tiny && req.qual.unf && !dis[`FPX_UNDERFLOW_TRAP_DISABLE];
         next_cause.ine = req.inexact && req.qual.ine && !dis[`FPX_INEXACT_TRAP_DISABLE];
         if (req.tiny && (!req.qual.unf || next_cause.unf)) begin
            next_result = '0;
         end
         if (is_cmp) begin
            next_result = pred_true(req) ? `FPX_TRUE_VAL : '0;
         end
      end
      next_trap = |next_cause;
      next_unpred = next_cause.ovf || next_cause.dze || next_cause.inv
         || next_cause.integer_overflow_exception || next_cause.unimpl;
   end

   // response to the exception path
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resp <= '0;
      end else begin
         resp.valid <= req.valid;
         if (req.valid) begin
            resp.trap <= next_trap;
            resp.unpredictable <= next_unpred;
            resp.rnd <= rnd_use;
            resp.cause <= next_cause;
            resp.result <= next_result;
         end
      end
   end

   // ahb-lite phases; reads take one wait state
   assign ap_ok = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         wr_addr <= 8'h00;
         rd_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= ap_ok && hwrite;
         rd_pend <= ap_ok && !hwrite;
         hreadyout <= !(ap_ok && !hwrite);
         if (ap_ok) begin
            wr_addr <= haddr[7:0];
            rd_addr <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_pend) begin
         case (rd_addr)
            `FPX_OFF_CTRL: hrdata <= {22'h000000, round_mode, 3'h0, dis};
            `FPX_OFF_STATUS: hrdata <= {25'h0000000, status};
            `FPX_OFF_MASK: hrdata <= {25'h0000000, mask};
            `FPX_OFF_COUNT: hrdata <= {16'h0000, trap_cnt};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // control and mask registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dis <= `FPX_DIS_RST;
         round_mode <= fpx_rnd_t'(`FPX_RND_RST);
         mask <= `FPX_MASK_RST;
      end else if (wr_pend) begin
         if (wr_addr == `FPX_OFF_CTRL) begin
            dis <= hwdata[`FPX_DIS_W-1:0];
            round_mode <= fpx_rnd_t'(hwdata[`FPX_RND_HI:`FPX_RND_LO]);
         end
         if (wr_addr == `FPX_OFF_MASK) begin
            mask <= hwdata[`FPX_CAUSE_W-1:0];
         end
      end
   end

   // sticky causes, set wins over write-one-clear
   assign w1c = (wr_pend && wr_addr == `FPX_OFF_STATUS) ? hwdata[`FPX_CAUSE_W-1:0] : '0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= '0;
         trap_cnt <= 16'h0000;
         irq <= 1'b0;
      end else begin
         status <= (status & ~w1c) | (req.valid ? next_cause : '0);
         if (req.valid && next_trap) begin
            trap_cnt <= trap_cnt + 16'h0001;
         end
         irq <= |(status & mask);
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic gen_op;
   assign gen_op = req.valid && !is_mv && !is_cmp && req.op != op_other
      && req.cls_a != cls_denorm && req.cls_b != cls_denorm;

   chk_move_quiet: assert property (req.valid && is_mv |=> resp.valid && !resp.trap
      && resp.result == $past(req.result)) else $error("move raised a trap or altered data");
   chk_inf_trap: assert property (gen_op && inf_in && !dis[`FPX_OVERFLOW_TRAP_DISABLE]
      |=> resp.trap && resp.cause.ovf && resp.unpredictable) else $error("infinity operand did not trap");
   chk_cmp_inf: assert property (req.valid && is_cmp && inf_in |=> !resp.cause.ovf)
      else $error("compare trapped on infinity");
   chk_nan_trap: assert property (req.valid && !is_mv && nan_in && !dis[`FPX_INVALID_TRAP_DISABLE]
      |=> resp.trap && resp.cause.inv) else $error("nan operand did not trap");
   chk_unf_plain: assert property (gen_op && req.tiny && !req.qual.unf
      |=> resp.result == 64'h0000000000000000 && !resp.cause.unf) else $error("underflow not plus zero");
   chk_unf_trap: assert property (gen_op && req.tiny && req.qual.unf && req.qual.sw && !dis[`FPX_UNDERFLOW_TRAP_DISABLE]
      |=> resp.trap && resp.cause.unf && resp.result == 64'h0000000000000000)
      else $error("underflow trap missing");
   chk_zero_sign: assert property (gen_op && !req.tiny
      |=> resp.result[63] == $past(req.result[63])) else $error("zero sign altered");
   chk_ine_trap: assert property (gen_op && req.inexact && req.qual.ine && !dis[`FPX_INEXACT_TRAP_DISABLE]
      |=> resp.trap && resp.cause.ine) else $error("inexact did not trap");
   chk_cmp_value: assert property (req.valid && is_cmp
      |=> resp.result == `FPX_TRUE_VAL || resp.result == 64'h0000000000000000) else $error("bad compare value");
   chk_rnd_echo: assert property (req.valid |=> resp.rnd == $past(rnd_use))
      else $error("rounding mode not carried");
   chk_irq_level: assert property (|(status & mask) |=> irq) else $error("interrupt missing");
   chk_read_wait: assert property (ap_ok && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   // request path checks
   chk_dze_trap: assert property (req.valid && !is_mv && req.dze && !dis[`FPX_DIVZERO_TRAP_DISABLE]
      |=> resp.trap && resp.cause.dze && resp.unpredictable)
      else $error("divide by zero did not trap");
   chk_ovf_flag: assert property (req.valid && !is_mv && req.ovf && !dis[`FPX_OVERFLOW_TRAP_DISABLE]
      |=> resp.trap && resp.cause.ovf && resp.unpredictable)
      else $error("overflow did not trap");
   chk_ovf_off: assert property (req.valid && dis[`FPX_OVERFLOW_TRAP_DISABLE]
      |=> !resp.cause.ovf)
      else $error("overflow trapped while disabled");
   chk_inv_off: assert property (req.valid && dis[`FPX_INVALID_TRAP_DISABLE]
      |=> !resp.cause.inv && !resp.cause.integer_overflow_exception)
      else $error("invalid trapped while disabled");
   chk_move_cause: assert property (req.valid && is_mv
      |=> resp.cause == '0)
      else $error("move reported a cause");
   chk_ine_qual: assert property (req.valid && !req.qual.ine
      |=> !resp.cause.ine)
      else $error("inexact trapped without qualifier");
   chk_unf_qual: assert property (req.valid && !req.qual.unf
      |=> !resp.cause.unf)
      else $error("underflow trapped without qualifier");
   chk_cmp_format: assert property (req.valid && is_cmp && req.fmt_a != req.fmt_b
      |=> resp.trap && resp.cause.unimpl)
      else $error("mixed format compare not handed to software");
   chk_op_software: assert property (req.valid && req.op == op_other
      |=> resp.trap && resp.cause.unimpl)
      else $error("software operation not handed over");
   chk_resp_pulse: assert property (req.valid
      |=> resp.valid)
      else $error("response missing");
   chk_resp_idle: assert property (!req.valid
      |=> !resp.valid)
      else $error("response without request");

   // status, count and bus checks
   chk_status_set: assert property (req.valid
      |=> (status & $past(next_cause)) == $past(next_cause))
      else $error("cause not recorded");
   chk_status_sticky: assert property (status != '0
      |=> (status & $past(status & ~w1c)) == $past(status & ~w1c))
      else $error("status bit lost");
   chk_cnt_step: assert property (req.valid && next_trap
      |=> trap_cnt == $past(trap_cnt) + 16'h0001)
      else $error("trap count not stepped");
   chk_cnt_hold: assert property (!(req.valid && next_trap)
      |=> trap_cnt == $past(trap_cnt))
      else $error("trap count moved");
   chk_irq_low: assert property (!(|(status & mask))
      |=> !irq)
      else $error("interrupt without cause");
   chk_write_nowait: assert property (ap_ok && hwrite
      |=> hreadyout)
      else $error("write inserted a wait state");
   chk_dis_write: assert property (wr_pend && wr_addr == `FPX_OFF_CTRL
      |=> dis == $past(hwdata[`FPX_DIS_W-1:0]))
      else $error("disable bits not written");
   chk_rnd_write: assert property (wr_pend && wr_addr == `FPX_OFF_CTRL
      |=> round_mode == $past(hwdata[`FPX_RND_HI:`FPX_RND_LO]))
      else $error("round mode not written");
   chk_mask_write: assert property (wr_pend && wr_addr == `FPX_OFF_MASK
      |=> mask == $past(hwdata[`FPX_CAUSE_W-1:0]))
      else $error("mask not written");

   cov_unf_trap: cover property (gen_op && req.tiny && req.qual.unf ##1 resp.cause.unf);
   cov_cmp_nan: cover property (req.valid && is_cmp && nan_in ##1 resp.trap);
   cov_irq: cover property (!irq ##1 irq);
   cov_move_snan: cover property (req.valid && is_mv && req.cls_a == cls_snan ##1 resp.valid && !resp.trap);
   cov_neg_zero: cover property (gen_op && !req.tiny && req.result == 64'h8000000000000000 ##1 resp.result[63]);
endmodule
`default_nettype wire

// ### verif/fpx_trap_unit_tb.sv
// self-checking testbench of the fp trap unit
`timescale 1ns/1ps
`default_nettype none
`include "fpx_defines.svh"
module fpx_trap_unit_tb import fpx_pkg::*;;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, prev_rdy;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] dis;
   logic [6:0] stat;
   logic [15:0] cnt;
   fpx_req_t req, r;
   fpx_resp_t resp, e;
   fpx_rnd_t round_mode, cur_rnd;
   fpx_resp_t exp_q[$];
   logic [31:0] rd_q[$];
   int seed = 43159;
   int bad_count = 0;
   int tests_run = 0;
   assign hready = hreadyout;
   fpx_trap_unit DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .req(req), .resp(resp), .round_mode(round_mode), .irq(irq));
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   task automatic complete_run;
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   function automatic int rn(input int n);
      return $unsigned($random(seed)) % n;
   endfunction
   function automatic fpx_resp_t model(input fpx_req_t q, input logic [4:0] d, input fpx_rnd_t m);
      fpx_resp_t x;
      logic inf, nan, den, cmp, t;
      x = '0;
      cmp = q.op == op_cmp;
      inf = q.cls_a == cls_inf || q.cls_b == cls_inf;
      nan = q.cls_a inside {cls_qnan, cls_snan} || q.cls_b inside {cls_qnan, cls_snan};
      den = q.cls_a == cls_denorm || q.cls_b == cls_denorm;
      x.rnd = q.qual.dyn_rnd ? m : q.qual.rnd;
      x.result = q.result;
      if (!(q.op inside {op_load, op_store, op_cpys})) begin
         x.cause.ovf = ((inf && !cmp) || q.ovf) && !d[`FPX_OVERFLOW_TRAP_DISABLE];
         x.cause.dze = q.dze && !d[`FPX_DIVZERO_TRAP_DISABLE];
         x.cause.inv = (nan || q.inv_new) && !d[`FPX_INVALID_TRAP_DISABLE];
         x.cause.integer_overflow_exception = q.integer_overflow_exception && q.op == op_cvt_fi && !d[`FPX_INVALID_TRAP_DISABLE];
         x.cause.unf = q.tiny && q.qual.unf && !d[`FPX_UNDERFLOW_TRAP_DISABLE];
         x.cause.ine = q.inexact && q.qual.ine && !d[`FPX_INEXACT_TRAP_DISABLE];
         x.cause.unimpl = q.op == op_other || (cmp && q.fmt_a != q.fmt_b) || den;
         if (q.tiny && (!q.qual.unf || x.cause.unf)) x.result = '0;
         case (q.pred)
            pr_eq: t = q.eq;
            pr_ne: t = !q.eq;
            pr_lt: t = q.lt;
            pr_le: t = q.lt | q.eq;
            pr_gt: t = !(q.lt | q.eq | q.unord);
            pr_ge: t = !(q.lt | q.unord);
            default: t = q.unord;
         endcase
         if (cmp) x.result = t ? `FPX_TRUE_VAL : 64'h0;
      end
      x.unpredictable = |{x.cause.ovf, x.cause.dze, x.cause.inv, x.cause.integer_overflow_exception, x.cause.unimpl};
      x.trap = |x.cause;
      x.valid = !x.unpredictable;
      return x;
   endfunction
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) chk(1'b0, 1'b1, "bus wait");
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      rd_q.push_back(x);
      bus(a, 1'b0, 32'h0);
   endtask
   task automatic send(input fpx_req_t q);
      fpx_resp_t x;
      x = model(q, dis, cur_rnd);
      @(posedge hclk);
      req <= q;
      exp_q.push_back(x);
      stat = stat | x.cause;
      cnt = cnt + 16'(x.trap);
   endtask
   always @(posedge hclk) begin
      if (resp.valid === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
         chk({resp.trap, resp.unpredictable, resp.rnd, resp.cause}, {e.trap, e.unpredictable, e.rnd, e.cause}, "resp");
         if (e.valid) chk(resp.result, e.result, "result");
      end
      if (hreadyout === 1'b1 && prev_rdy === 1'b0) begin
         chk(hrdata, rd_q.pop_front(), "read");
         chk(hresp, 1'b0, "hresp");
      end
      prev_rdy = hreadyout;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      complete_run();
   end
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      req = '0;
      stat = '0;
      cnt = '0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`FPX_OFF_CTRL, 32'h00000200);
      rd(`FPX_OFF_STATUS, 32'h0);
      rd(`FPX_OFF_MASK, 32'h0);
      rd(8'h10, 32'h0);
      for (int b = 0; b < 8; b++) begin
         dis = (b == 0) ? 5'h00 : 5'($random(seed));
         cur_rnd = fpx_rnd_t'(rn(4));
         bus(`FPX_OFF_CTRL, 1'b1, {22'h0, cur_rnd, 3'h0, dis});
         rd(`FPX_OFF_CTRL, {22'h0, cur_rnd, 3'h0, dis});
         chk(round_mode, cur_rnd, "round mode");
         repeat (40) begin
            r = fpx_req_t'(95'({$random(seed), $random(seed), $random(seed)}));
            r.valid = 1'b1;
            r.op = fpx_op_t'(rn(12));
            r.qual.rnd = fpx_rnd_t'(rn(4));
            r.pred = fpx_pred_t'(rn(7));
            r.cls_a = fpx_cls_t'(rn(6));
            r.cls_b = (rn(3) == 0) ? fpx_cls_t'(rn(6)) : cls_finite;
            {r.ovf, r.dze, r.inv_new, r.integer_overflow_exception} = (rn(2) == 0) ? 4'($random(seed)) : 4'h0;
            r.unord = r.cls_a inside {cls_qnan, cls_snan} || r.cls_b inside {cls_qnan, cls_snan};
            if (r.unord) {r.lt, r.eq} = 2'h0;
            if (r.op == op_cmp) {r.tiny, r.ovf} = 2'h0;
            r.result = (rn(4) == 0) ? 64'h8000000000000000 : {$random(seed), $random(seed)};
            send(r);
         end
         @(posedge hclk);
         req <= '0;
      end
      repeat (3) @(posedge hclk);
      rd(`FPX_OFF_STATUS, {25'h0, stat});
      rd(`FPX_OFF_COUNT, {16'h0, cnt});
      bus(`FPX_OFF_COUNT, 1'b1, 32'h0000FFFF);
      rd(`FPX_OFF_COUNT, {16'h0, cnt});
      chk(irq, 1'b0, "irq masked");
      bus(`FPX_OFF_MASK, 1'b1, 32'h0000007F);
      repeat (2) @(posedge hclk);
      #1 chk(irq, stat != 7'h0, "irq raised");
      bus(`FPX_OFF_STATUS, 1'b1, 32'h0000007F);
      stat = '0;
      repeat (2) @(posedge hclk);
      #1 chk(irq, 1'b0, "irq cleared");
      rd(`FPX_OFF_STATUS, 32'h0);
      bus(`FPX_OFF_MASK, 1'b1, 32'h00000000);
      r = '0;
      r.valid = 1'b1;
      r.op = op_other;
      send(r);
      @(posedge hclk);
      req <= '0;
      repeat (3) @(posedge hclk);
      #1 chk(irq, 1'b0, "irq mask off");
      rd(`FPX_OFF_STATUS, 32'h00000020);
      chk(exp_q.size(), 0, "resp missing");
      complete_run();
   end
endmodule
`default_nettype wire
